// >>> rtl/llmc_defines.svh
// Offsets, field positions, reset values and timing for the loop test block
`ifndef LLMC_DEFINES_SVH
`define LLMC_DEFINES_SVH
`define LLMC_OFS_HDR        8'h00
`define LLMC_OFS_VHDR       8'h04
`define LLMC_OFS_CTRL       8'h08
`define LLMC_OFS_STAT       8'h0C
`define LLMC_OFS_TALLY_LO   8'h10
`define LLMC_OFS_TALLY_HI   8'h14
`define LLMC_CAP_ID         16'h000B
`define LLMC_CAP_VER        4'h1
`define LLMC_VCAP_LEN       12'h018
`define LLMC_CAP_BASE_DW    10'h040
`define LLMC_NEXT_PTR       12'h000
`define LLMC_CTRL_START     0
`define LLMC_CTRL_FORCE     1
`define LLMC_CTRL_SPD_LO    2
`define LLMC_CTRL_DEEMPH    4
`define LLMC_CTRL_MODCOMP   5
`define LLMC_CTRL_SKIPSUP   6
`define LLMC_CTRL_W         7
`define LLMC_CTRL_RST       7'h00
`define LLMC_STAT_SLAVE     0
`define LLMC_STAT_FAIL      1
`define LLMC_STAT_TESTED    8
`define LLMC_L0_STATE       6'h16
`define LLMC_CLK_HZ         40000000
`define LLMC_MS_PER_S       1000
`define LLMC_SLAVE_WAIT_MS  100
`endif

// >>> rtl/llmc_pkg.sv
// Types shared by the loop test block
package llmc_pkg;
   typedef enum logic [1:0]
   {
      LLMC_IDLE    = 2'b00,
      LLMC_WAIT_TS = 2'b01,
      LLMC_TESTING = 2'b10,
      LLMC_FAILED  = 2'b11
   } llmc_state_e;
   typedef logic [7:0] llmc_tally_t;
endpackage

// >>> rtl/llmc_lane_tally.sv
// Per-lane tested flags and saturating line-error counters
`timescale 1ns/1ps
module llmc_lane_tally
   import llmc_pkg::*;
#(
   parameter int LANES = 8
)
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // Control
   input  wire logic                 clear,
   input  wire logic                 count_en,
   input  wire logic [LANES-1:0]     lane_mark,
   input  wire logic [LANES-1:0]     code_err,
   // Results
   output logic      [LANES-1:0]     tested_q,
   output logic      [8*LANES-1:0]   tally_q
);
   llmc_tally_t cnt_q [LANES];
   logic [LANES-1:0] tested_d;
   assign tested_d = (clear ? '0 : tested_q) | (lane_mark & {LANES{count_en}});

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         tested_q <= '0;
      else
         tested_q <= tested_d; // Mark wins over clear [R17] [R18]
   end

   for (genvar i = 0; i < LANES; i++)
   begin : g_lane
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
            cnt_q[i] <= 8'h00;
         else if (clear)
            cnt_q[i] <= 8'h00; // [R22]
         else if (count_en && tested_q[i] && code_err[i] &&
                  cnt_q[i] != 8'hFF)
            cnt_q[i] <= cnt_q[i] + 8'h01; // Saturates, never wraps [R22]
      end
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
            tally_q[8*i +: 8] <= 8'h00;
         else
            tally_q[8*i +: 8] <= tested_d[i] ? cnt_q[i] : 8'h00; // [R23]
      end
   end
endmodule // llmc_lane_tally

// >>> rtl/llmc_loop_cap.sv
// Loopback-master test capability: config words, control FSM, lane results
//
// Overview of operation
// R01: Header word reads capability id 000Bh, version 1h, next pointer.
// R02: Vendor header word at 04h reports structure length of 24 bytes.
// R03: Control at 08h, status at 0Ch, error tallies at 10h and 14h.
// R04: Start bit one while link state is L0 enters loopback master.
// R05: Clearing the start bit leaves loopback master mode.
// R06: Software must not set start during a link speed change.
// R07: Force bit pushes a slave lacking symbol lock into loopback active.
// R08: Software must set start whenever it sets force.
// R09: Control bits 3:2 give the speed advertised in loopback training sets.
// R10: Control bit 4 gives advertised de-emphasis, also used by the slave.
// R11: Bit 5 selects modified compliance with one skip set, else plain.
// R12: Bit 6 suppresses skip sets; ignored when bit 5 is zero.
// R13: Status bit 0 shows the device is acting as loopback slave.
// R14: Software must not set start while the slave status bit is one.
// R15: Status bit 1 sets if no loopback training set within 100 ms.
// R16: Slave-failed never sets with force high; start write clears it; a timeout in the write cycle still sets it.
// R17: Writing start to one clears tested bits 15:8; lanes in use while testing stay set.
// R18: Status bit 8+n sets once lane n was tested, tally then valid.
// R19: Software uses the test only while the application is idle.
// R20: Software drives the test through the configuration port words.
// R21: The capability exists for root port and endpoint alike.
// R22: Per-lane 8-bit tallies count code errors, packed low byte up.
// R23: Untested lanes report a zero tally.
// R24: Software addresses the words by dword address on the port.
// R25: Reserved control and status bits read zero, writes ignored.
`timescale 1ns/1ps
`include "llmc_defines.svh"
module llmc_loop_cap
   import llmc_pkg::*;
#(
   parameter int           LANES      = 8,
   parameter int           MS_CYCLES  = `LLMC_CLK_HZ / `LLMC_MS_PER_S,
   parameter int           WAIT_MS    = `LLMC_SLAVE_WAIT_MS,
   parameter logic [9:0]   BASE_DW    = `LLMC_CAP_BASE_DW,
   parameter logic [11:0]  NEXT_PTR   = `LLMC_NEXT_PTR,
   // Arbitrary vendor id and revision values
   parameter logic [15:0]  VENDOR_ID  = 16'h0001,
   parameter logic [3:0]   VENDOR_REV = 4'h0
)
(
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // Configuration port
   input  wire logic [9:0]   cfg_dwaddr,
   input  wire logic [31:0]  cfg_di,
   input  wire logic [3:0]   cfg_byte_en,
   input  wire logic         cfg_wr_en,
   input  wire logic         cfg_rd_en,
   output logic      [31:0]  cfg_do,
   output logic              cfg_rd_wr_done,
   // Physical layer status
   input  wire logic [5:0]   link_train_state,
   input  wire logic         slave_loop_active,
   input  wire logic         rx_ts1_loop,
   input  wire logic [7:0]   lane_in_use,
   input  wire logic [7:0]   rx_code_err,
   // Physical layer control
   output logic              loop_master_en,
   output logic              loop_force_out,
   output logic      [1:0]   loop_speed,
   output logic              loop_deemph_bit,
   output logic              mod_compliance_en,
   output logic      [1:0]   skip_os_count,
   output logic              loop_active
);
   // Register state
   logic [`LLMC_CTRL_W-1:0]  ctrl_q;
   logic [`LLMC_CTRL_W-1:0]  ctrl_d;
   logic [7:0]               ctrl_merged;
   logic                     fail_q;
   logic                     fail_d;
   logic                     slave_q;
   logic                     done_q;
   logic [31:0]              rdata_d;
   llmc_state_e              state_q;
   llmc_state_e              state_d;

   // Timers
   logic [15:0]              ms_div_q;
   logic                     ms_tick;
   logic [7:0]               wait_ms_q;
   logic                     wait_done;

   // Lane results
   logic [7:0]               tested;
   logic [63:0]              tally;

   // Decode
   logic                     req;
   logic                     in_cap;
   logic [7:0]               byte_ofs;
   logic                     wr_ctrl;
   logic                     start_wr;
   logic                     start;
   logic                     force_bit;
   logic                     in_l0;
   logic                     ts_ok;
   logic                     count_en;

   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       en);
      merge_byte = en ? new_v : old_v;
   endfunction

   // Same decode for root port and endpoint builds [R21]
   assign req       = (cfg_wr_en || cfg_rd_en) && !done_q;
   assign in_cap    = (cfg_dwaddr >= BASE_DW) &&
                      (cfg_dwaddr <  BASE_DW + 10'd6);
   assign byte_ofs  = {cfg_dwaddr[5:0] - BASE_DW[5:0], 2'b00}; // [R24]
   assign wr_ctrl   = req && cfg_wr_en && in_cap &&
                      byte_ofs == `LLMC_OFS_CTRL; // [R03]
   assign start_wr  = wr_ctrl && cfg_byte_en[0] &&
                      cfg_di[`LLMC_CTRL_START];
   assign start     = ctrl_q[`LLMC_CTRL_START];
   assign force_bit = ctrl_q[`LLMC_CTRL_FORCE];
   assign in_l0     = link_train_state == `LLMC_L0_STATE;

   // Only bits 6:0 exist; the rest of the word is dropped [R25]
   assign ctrl_merged = merge_byte({1'b0, ctrl_q}, cfg_di[7:0],
                                   cfg_byte_en[0]);
   assign ctrl_d = wr_ctrl ? ctrl_merged[`LLMC_CTRL_W-1:0] : ctrl_q;

   // Read mux
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (in_cap)
      begin
         unique case (byte_ofs)
            `LLMC_OFS_HDR:
               rdata_d = {NEXT_PTR, `LLMC_CAP_VER, `LLMC_CAP_ID}; // [R01]
            `LLMC_OFS_VHDR:
               rdata_d = {`LLMC_VCAP_LEN, VENDOR_REV, VENDOR_ID}; // [R02]
            `LLMC_OFS_CTRL:
               rdata_d = {25'h000_0000, ctrl_q}; // [R03] [R25]
            `LLMC_OFS_STAT:
               rdata_d = {16'h0000, tested, 6'h00, fail_q,
                          slave_q}; // [R13] [R18] [R25]
            `LLMC_OFS_TALLY_LO:
               rdata_d = tally[31:0]; // [R22]
            `LLMC_OFS_TALLY_HI:
               rdata_d = tally[63:32]; // [R22]
            default:
               rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Config port: one answer per held request, then it must drop
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         done_q <= 1'b0;
         cfg_do <= 32'h0000_0000;
      end
      else
      begin
         done_q <= req;
         if (req && cfg_rd_en)
            cfg_do <= rdata_d;
      end
   end
   assign cfg_rd_wr_done = done_q;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         ctrl_q <= `LLMC_CTRL_RST;
      else
         ctrl_q <= ctrl_d;
   end

   // Slave indication is a plain level from the link logic
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         slave_q <= 1'b0;
      else
         slave_q <= slave_loop_active; // [R13]
   end

   // 1 ms enable, then a count of ms; keeps the long wait cheap
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         ms_div_q <= 16'h0000;
      else if (state_q != LLMC_WAIT_TS || ms_tick)
         ms_div_q <= 16'h0000;
      else
         ms_div_q <= ms_div_q + 16'h0001;
   end
   assign ms_tick = ms_div_q == 16'(MS_CYCLES - 1);

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         wait_ms_q <= 8'h00;
      else if (state_q != LLMC_WAIT_TS)
         wait_ms_q <= 8'h00;
      else if (ms_tick)
         wait_ms_q <= wait_ms_q + 8'h01;
   end
   assign wait_done = ms_tick && wait_ms_q == 8'(WAIT_MS - 1); // [R15]

   // Master state machine
   assign ts_ok = rx_ts1_loop || force_bit; // [R07]

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         LLMC_IDLE:
            if (start && in_l0 && !slave_q)
               state_d = LLMC_WAIT_TS; // [R04]
         LLMC_WAIT_TS:
            if (!start)
               state_d = LLMC_IDLE; // [R05]
            else if (ts_ok)
               state_d = LLMC_TESTING;
            else if (wait_done)
               state_d = LLMC_FAILED;
         LLMC_TESTING:
            if (!start)
               state_d = LLMC_IDLE; // [R05]
         LLMC_FAILED:
            if (!start)
               state_d = LLMC_IDLE; // [R05]
            else if (ts_ok)
               state_d = LLMC_TESTING;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         state_q <= LLMC_IDLE;
      else
         state_q <= state_d;
   end

   // Timeout sets; start write clears; force blocks the set
   assign fail_d = (state_q == LLMC_WAIT_TS && wait_done &&
                    !ts_ok && start && !force_bit) ? 1'b1 :
                   start_wr ? 1'b0 : fail_q; // [R15] [R16]

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         fail_q <= 1'b0;
      else
         fail_q <= fail_d;
   end

   // Lanes only count while the loop is really running
   assign count_en = state_q == LLMC_TESTING;

   llmc_lane_tally #(
      .LANES       (LANES)
   ) u_tally (
      .core_clk    (core_clk),
      .rst         (rst),
      .clear       (start_wr), // [R17] [R22]
      .count_en    (count_en),
      .lane_mark   (lane_in_use), // [R18] [R23]
      .code_err    (rx_code_err),
      .tested_q    (tested),
      .tally_q     (tally)
   );

   // Link controls, registered
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         loop_master_en    <= 1'b0;
         loop_force_out    <= 1'b0;
         loop_speed        <= 2'b00;
         loop_deemph_bit   <= 1'b0;
         mod_compliance_en <= 1'b0;
         skip_os_count     <= 2'd2;
         loop_active       <= 1'b0;
      end
      else
      begin
         loop_master_en    <= state_d != LLMC_IDLE; // [R04] [R05]
         loop_force_out    <= force_bit && start; // [R07] [R08]
         loop_speed        <= ctrl_q[`LLMC_CTRL_SPD_LO +: 2]; // [R09]
         loop_deemph_bit   <= ctrl_q[`LLMC_CTRL_DEEMPH]; // [R10]
         mod_compliance_en <= ctrl_q[`LLMC_CTRL_MODCOMP]; // [R11]
         if (!ctrl_q[`LLMC_CTRL_MODCOMP])
            skip_os_count <= 2'd2; // Suppress bit ignored here [R11] [R12]
         else if (ctrl_q[`LLMC_CTRL_SKIPSUP])
            skip_os_count <= 2'd0; // [R12]
         else
            skip_os_count <= 2'd1; // [R11]
         loop_active       <= state_d == LLMC_TESTING;
      end
   end
endmodule // llmc_loop_cap

// >>> sim/llmc_assertions.sv
// Checker on the config port and link controls of the loop block
`timescale 1ns/1ps
module llmc_assertions
#(
   parameter logic [9:0] BASE_DW = 10'h040
)
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Config port
   input  wire logic [9:0]  cfg_dwaddr,
   input  wire logic [31:0] cfg_di,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic        cfg_wr_en,
   input  wire logic        cfg_rd_en,
   input  wire logic [31:0] cfg_do,
   input  wire logic        cfg_rd_wr_done,
   // Link side
   input  wire logic [5:0]  link_train_state,
   input  wire logic        slave_loop_active,
   input  wire logic        loop_master_en,
   input  wire logic        mod_compliance_en,
   input  wire logic [1:0]  skip_os_count,
   input  wire logic        loop_active
);
   // Offset wraps below base, so one compare covers both sides
   wire [9:0] ofs  = cfg_dwaddr - BASE_DW;
   wire       rd_t = cfg_rd_en & ~cfg_rd_wr_done;
   wire       wc   = cfg_wr_en & ~cfg_rd_wr_done & cfg_byte_en[0]
                     & (ofs == 10'd2);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_done_follows: assert property ((cfg_rd_en | cfg_wr_en)
      && !cfg_rd_wr_done |=> cfg_rd_wr_done) else $error("no done");
   chk_done_single: assert property (cfg_rd_wr_done
      |=> !cfg_rd_wr_done) else $error("done too long");
   chk_hdr_id: assert property (rd_t && ofs == 10'd0
      |=> cfg_do[19:0] == 20'h1_000B) else $error("bad header");
   chk_len_field: assert property (rd_t && ofs == 10'd1
      |=> cfg_do[31:20] == 12'h018) else $error("bad length");
   chk_unmapped_zero: assert property (rd_t && ofs > 10'd5
      |=> cfg_do == 32'h0000_0000) else $error("unmapped not zero");
   chk_ctrl_rsvd: assert property (rd_t && ofs == 10'd2
      |=> cfg_do[31:7] == 25'h0) else $error("ctrl reserved set");
   chk_stat_rsvd: assert property (rd_t && ofs == 10'd3
      |=> cfg_do[31:16] == 16'h0000 && cfg_do[7:2] == 6'h00)
      else $error("status reserved set");
   chk_entry_in_l0: assert property (wc && cfg_di[0]
      && link_train_state == 6'h16 && !slave_loop_active
      && !loop_master_en |-> ##2 loop_master_en) else $error("no entry");
   chk_exit_on_clear: assert property (wc && !cfg_di[0]
      |-> ##2 !loop_master_en) else $error("no exit");
   chk_skip_plain: assert property (!mod_compliance_en
      |-> skip_os_count == 2'd2) else $error("skip count wrong");
   cover property (rd_t && ofs == 10'd3);
   cover property ($rose(loop_active));
   cover property (loop_master_en && !loop_active [*8]);
endmodule // llmc_assertions

// >>> sim/llmc_link_partner.sv
// Link partner model: loopback slave answers and lane error source
`timescale 1ns/1ps
module llmc_link_partner
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Scenario controls
   input  wire logic       in_l0,
   input  wire logic       as_slave,
   input  wire logic [4:0] ts_delay,
   input  wire logic [7:0] lanes,
   input  wire logic [7:0] err_mask,
   // From the device
   input  wire logic       loop_master_en,
   input  wire logic       loop_active,
   // To the device
   output logic      [5:0] link_train_state,
   output logic            slave_loop_active,
   output logic            rx_ts1_loop,
   output logic      [7:0] lane_in_use,
   output logic      [7:0] rx_code_err
);
   logic [4:0] wait_q;
   logic [4:0] act_q;
   assign link_train_state  = in_l0 ? 6'h16 : 6'h0B;
   assign slave_loop_active = as_slave;
   assign lane_in_use       = lanes;
   // Zero delay: a slave without symbol lock stays silent
   assign rx_ts1_loop = (ts_delay != 5'h00) && (wait_q >= ts_delay);
   // Errors start late so tested bits are settled first
   assign rx_code_err = (act_q >= 5'd4 && act_q < 5'd7) ? err_mask
                                                        : 8'h00;
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         wait_q <= 5'h00;
      else
         wait_q <= (loop_master_en && !loop_active)
                   ? wait_q + {4'h0, ~&wait_q} : 5'h00;
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         act_q <= 5'h00;
      else
         act_q <= loop_active ? act_q + {4'h0, ~&act_q} : 5'h00;
endmodule // llmc_link_partner

// >>> sim/tb_llmc_loop_cap.sv
// Testbench: config-port tests of the loop test capability
`timescale 1ns/1ps
module tb_llmc_loop_cap;
   localparam logic [9:0]  BASE = 10'h040;
   localparam logic [15:0] VID  = 16'h00A5; // Arbitrary value
   localparam logic [31:0] TBL [5] = '{32'hFFFF_FFFF, 32'h0000_0040,
      32'h0000_0020, 32'h0000_0060, 32'h0000_0000};
   logic        core_clk, rst, cfg_wr_en, cfg_rd_en, cfg_rd_wr_done;
   logic [9:0]  cfg_dwaddr;
   logic [31:0] cfg_di, cfg_do, q, d;
   logic [3:0]  cfg_byte_en;
   logic [5:0]  link_train_state;
   logic        slave_loop_active, rx_ts1_loop, in_l0, as_slave;
   logic [7:0]  lane_in_use, rx_code_err, lanes, err_mask, outs;
   logic        loop_master_en, loop_force_out, loop_deemph_bit;
   logic        mod_compliance_en, loop_active;
   logic [1:0]  loop_speed, skip_os_count, sk;
   logic [4:0]  ts_delay;
   int          fails, samples_checked;
   assign outs = {loop_force_out, loop_speed, loop_deemph_bit,
                  mod_compliance_en, skip_os_count, loop_master_en};
   llmc_loop_cap #(.MS_CYCLES(4), .WAIT_MS(3), .BASE_DW(BASE),
      .VENDOR_ID(VID)) llmc_loop_cap_i (.core_clk, .rst, .cfg_dwaddr,
      .cfg_di, .cfg_byte_en, .cfg_wr_en, .cfg_rd_en, .cfg_do,
      .cfg_rd_wr_done, .link_train_state, .slave_loop_active,
      .rx_ts1_loop, .lane_in_use, .rx_code_err, .loop_master_en,
      .loop_force_out, .loop_speed, .loop_deemph_bit,
      .mod_compliance_en, .skip_os_count, .loop_active);
   llmc_link_partner llmc_link_partner_i (.core_clk, .rst, .in_l0,
      .as_slave, .ts_delay, .lanes, .err_mask, .loop_master_en,
      .loop_active, .link_train_state, .slave_loop_active,
      .rx_ts1_loop, .lane_in_use, .rx_code_err);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task acc(input logic wr, input logic [2:0] o, input logic [31:0] dat);
      int n;
      @(posedge core_clk);
      cfg_dwaddr  <= BASE + {7'h00, o}; // Dword address
      cfg_di      <= dat;
      cfg_byte_en <= 4'hF;
      cfg_wr_en   <= wr;
      cfg_rd_en   <= !wr;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (cfg_rd_wr_done !== 1'b1 && n < 8);
      chk({31'h0, cfg_rd_wr_done}, 32'h0000_0001);
      q = cfg_do;
      cfg_wr_en <= 1'b0;
      cfg_rd_en <= 1'b0;
   endtask
   task rd(input logic [2:0] o, input logic [31:0] exp);
      acc(1'b0, o, 32'h0000_0000);
      chk(q, exp);
   endtask
   task wait_act();
      int n;
      n = 0;
      while (loop_active !== 1'b1 && n < 40)
      begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, loop_active}, 32'h0000_0001);
      repeat (20) @(posedge core_clk);
   endtask
   task wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial
   begin
      #(25 * 4000);
      fails++;
      $display("watchdog expired");
      wrap_up();
   end
   initial
   begin
      fails = 0;
      samples_checked = 0;
      rst = 1'b1;
      {cfg_wr_en, cfg_rd_en, cfg_di, cfg_dwaddr, cfg_byte_en} = '0;
      {in_l0, as_slave, ts_delay} = '0;
      lanes    = 8'h0F;
      err_mask = 8'h15;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rd(3'd0, {12'h000, 4'h1, 16'h000B});
      rd(3'd1, {12'h018, 4'h0, VID});
      for (int i = 2; i < 8; i++)
         rd(i[2:0], 32'h0000_0000);
      $display("test words done");
      // Out of L0 a start bit is only stored
      foreach (TBL[k])
      begin
         d = TBL[k];
         acc(1'b1, 3'd2, d);
         sk = !d[5] ? 2'd2 : (d[6] ? 2'd0 : 2'd1);
         rd(3'd2, d & 32'h0000_007F);
         chk({24'h0, outs}, {24'h0, d[1] & d[0], d[3:2], d[4], d[5],
             sk, 1'b0});
      end
      $display("test control done");
      // Start in steady L0, not as slave, runs the loop until start clears
      in_l0    <= 1'b1;
      ts_delay <= 5'd8;
      acc(1'b1, 3'd2, 32'h0000_0001);
      wait_act();
      rd(3'd3, 32'h0000_0F00);
      rd(3'd4, 32'h0003_0003);
      rd(3'd5, 32'h0000_0000);
      acc(1'b1, 3'd2, 32'h0000_0000);
      @(posedge core_clk);
      chk({31'h0, loop_master_en}, 32'h0000_0000);
      $display("test loop done");
      ts_delay <= 5'd0;
      acc(1'b1, 3'd2, 32'h0000_0001);
      rd(3'd3, 32'h0000_0000);
      rd(3'd4, 32'h0000_0000);
      repeat (16) @(posedge core_clk);
      rd(3'd3, 32'h0000_0002);
      acc(1'b1, 3'd2, 32'h0000_0000);
      acc(1'b1, 3'd2, 32'h0000_0001);
      rd(3'd3, 32'h0000_0000);
      acc(1'b1, 3'd2, 32'h0000_0003);
      wait_act();
      rd(3'd3, 32'h0000_0F00);
      acc(1'b1, 3'd2, 32'h0000_0000);
      $display("test fail done");
      as_slave <= 1'b1;
      rd(3'd3, 32'h0000_0F01);
      as_slave <= 1'b0;
      $display("test slave done");
      wrap_up();
   end
endmodule // tb_llmc_loop_cap
bind llmc_loop_cap llmc_assertions #(.BASE_DW(BASE_DW))
   llmc_assertions_i (.core_clk, .rst, .cfg_dwaddr, .cfg_di,
   .cfg_byte_en, .cfg_wr_en, .cfg_rd_en, .cfg_do, .cfg_rd_wr_done,
   .link_train_state, .slave_loop_active, .loop_master_en,
   .mod_compliance_en, .skip_os_count, .loop_active);
